//--- design/crc16_ccitt_byte_generator.sv
// Decided for this implementation: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ns
module crc16_ccitt_byte_generator (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // avalon-mm slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef enum logic [1:0] {
    st_idle   = 2'b01,
    st_armed  = 2'b10
  } seed_e;

  seed_e       seed_q, seed_d;
  logic [15:0] crc_q, crc_d;
  logic [7:0]  data_q, data_d;
  logic        pend_q, pend_d;
  logic [1:0]  ctl_q, ctl_d;
  logic [31:0] rdata_q, rdata_d;
  logic        ack_q, ack_d;
  logic [15:0] step_out;

  logic wr_lo, wr_hi, wr_ctl, frozen, deep;
  logic rd_new, wr_new;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  // register select, used by the write strobes; the read path decodes address in its own case
  function automatic logic hit(input logic [3:0] addr, input logic [3:0] idx);
    return addr == idx;
  endfunction : hit

  // one register byte onto the low lane of the bus word
  function automatic logic [31:0] lane0(input logic [7:0] b);
    return {24'h000000, b};
  endfunction : lane0

  // bit at a time form of the step; the assertions hold the unrolled
  // module against it, so a slip in either one shows up
  function automatic logic [15:0] serial_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = crc_pkg::bits_per_byte - 1; i >= 0; i--) begin
      r = {r[14:0], 1'b0} ^ ((r[15] ^ b[i]) ? crc_pkg::crc_poly : 16'h0000);
    end
    return r;
  endfunction : serial_step

  ////////////////////////////////////////////////////////////////////////////
  // bus decode; byte lane 0 carries the register bytes
  assign frozen = ctl_q[crc_pkg::ctl_stop_light];
  assign deep   = ctl_q[crc_pkg::ctl_stop_deep];
  // first cycle of an access; the second one only answers
  assign rd_new = read & ~ack_q;
  assign wr_new = write & ~ack_q & byteenable[0];
  // one wait cycle, so every access answers on the second edge
  assign waitrequest = (read | write) & ~ack_q;
  // a frozen block holds off crc register writes until resume; the refused
  // write is still answered, so software never stalls on it
  assign wr_hi  = wr_new & ~frozen & hit(address, crc_pkg::idx_result_high);
  assign wr_lo  = wr_new & ~frozen & hit(address, crc_pkg::idx_result_low);
  assign wr_ctl = wr_new & hit(address, crc_pkg::idx_control);
  assign readdata = rdata_q;

  crc_byte_step u_step (
    .crc_in  (crc_q),
    .data_in (data_q),
    .crc_out (step_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // generator: seed sequence, data byte and shift register
  always_comb begin
    seed_d  = seed_q;
    crc_d   = crc_q;
    data_d  = data_q;
    pend_d  = pend_q;
    // the byte step completes one edge after the write is taken, on the same edge that takes the answer
    if (pend_q && !frozen) begin
      crc_d  = step_out;
      pend_d = 1'b0;
    end
    if (wr_hi) begin
      crc_d[15:8] = writedata[7:0];
      seed_d      = st_armed;
      pend_d      = 1'b0;
    end else if (wr_lo) begin
      case (seed_q)
        st_armed: begin
          crc_d[7:0] = writedata[7:0];
          seed_d     = st_idle;
        end
        st_idle: begin
          data_d = writedata[7:0];
          pend_d = 1'b1;
        end
        default: seed_d = st_idle;
      endcase
    end
    // deep stop: block unpowered, comes back in reset state
    if (deep) begin
      crc_d  = crc_pkg::crc_reset_value;
      seed_d = st_idle;
      pend_d = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clock) begin
    if (!resetn) begin
      seed_q  <= st_idle;
      crc_q   <= crc_pkg::crc_reset_value;
      data_q  <= 8'h00;
      pend_q  <= 1'b0;
    end else begin
      seed_q  <= seed_d;
      crc_q   <= crc_d;
      data_q  <= data_d;
      pend_q  <= pend_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus answer: acknowledge and registered read data
  always_comb begin
    ack_d   = (read | write) & ~ack_q;
    rdata_d = rdata_q;
    // reads follow the next crc value, so a read that meets a step sees it
    if (rd_new) begin
      case (address)
        crc_pkg::idx_result_high: rdata_d = lane0(crc_d[15:8]);
        crc_pkg::idx_result_low:  rdata_d = lane0(crc_d[7:0]);
        crc_pkg::idx_control:     rdata_d = {30'h00000000, ctl_q};
        crc_pkg::idx_status:      rdata_d = {29'h00000000, pend_q, frozen,
                                             seed_q == st_armed};
        default:                  rdata_d = crc_pkg::unmapped_value;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control: light and deep stop requests; deep stop is a level, so the
  // generator stays in its reset state for as long as it is set
  always_comb begin
    ctl_d = ctl_q;
    if (wr_ctl) begin
      ctl_d = {writedata[crc_pkg::ctl_stop_deep], writedata[crc_pkg::ctl_stop_light]};
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      ctl_q <= 2'h0;
    end else begin
      ctl_q <= ctl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  seed_high_load_a: assert property (@(posedge clock) disable iff (!resetn)
    wr_hi && !deep |=> crc_q[15:8] == $past(writedata[7:0]) && seed_q == st_armed)
    else $error("high write did not load seed");
  seed_low_load_a: assert property (@(posedge clock) disable iff (!resetn)
    wr_lo && seed_q == st_armed && !deep |=> crc_q[7:0] == $past(writedata[7:0])
    && !pend_q)
    else $error("armed low write not a seed");
  data_byte_a: assert property (@(posedge clock) disable iff (!resetn)
    wr_lo && seed_q == st_idle && !deep |=> pend_q)
    else $error("data byte not taken");
  no_early_shift_a: assert property (@(posedge clock) disable iff (!resetn)
    seed_q == st_armed |-> !pend_q)
    else $error("shift while seed armed");
  step_done_a: assert property (@(posedge clock) disable iff (!resetn)
    pend_q && !frozen && !deep && !wr_hi |=> crc_q == $past(step_out) && !pend_q)
    else $error("byte step not done in one cycle");
  read_high_a: assert property (@(posedge clock) disable iff (!resetn)
    read && !ack_q && address == crc_pkg::idx_result_high && !deep
    |=> readdata[7:0] == crc_q[15:8] && !waitrequest)
    else $error("high read wrong");
  read_low_a: assert property (@(posedge clock) disable iff (!resetn)
    read && !ack_q && address == crc_pkg::idx_result_low && !deep
    |=> readdata[7:0] == crc_q[7:0])
    else $error("low read wrong");
  freeze_hold_a: assert property (@(posedge clock) disable iff (!resetn)
    frozen && !deep && !wr_ctl |=> $stable(crc_q))
    else $error("crc moved while frozen");
  deep_reset_a: assert property (@(posedge clock) disable iff (!resetn)
    deep |=> crc_q == crc_pkg::crc_reset_value && seed_q == st_idle)
    else $error("deep stop did not reset");

  // bus timing and read data
  one_wait_a: assert property (@(posedge clock) disable iff (!resetn)
    waitrequest |=> ack_q)
    else $error("access not answered after one wait");

  ack_pulse_a: assert property (@(posedge clock) disable iff (!resetn)
    ack_q |=> !ack_q)
    else $error("answer stood longer than one cycle");

  read_upper_a: assert property (@(posedge clock) disable iff (!resetn)
    read && ack_q |-> readdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");

  unmapped_read_a: assert property (@(posedge clock) disable iff (!resetn)
    rd_new && address > crc_pkg::idx_status |=> readdata == crc_pkg::unmapped_value)
    else $error("unmapped read not zero");

  status_read_a: assert property (@(posedge clock) disable iff (!resetn)
    rd_new && address == crc_pkg::idx_status
    |=> readdata[crc_pkg::sts_seed_armed] == $past(seed_q == st_armed)
    && readdata[crc_pkg::sts_frozen] == $past(frozen)
    && readdata[crc_pkg::sts_pending] == $past(pend_q))
    else $error("status read wrong");

  // generator
  step_ref_a: assert property (@(posedge clock) disable iff (!resetn)
    pend_q |-> step_out == serial_step(crc_q, data_q))
    else $error("byte step differs from bit serial form");

  reset_state_a: assert property (@(posedge clock)
    $rose(resetn) |-> crc_q == crc_pkg::crc_reset_value && seed_q == st_idle && !pend_q)
    else $error("state after reset not clear");

  seed_no_shift_a: assert property (@(posedge clock) disable iff (!resetn)
    wr_lo && seed_q == st_armed && !deep |=> crc_q[15:8] == $past(crc_q[15:8]))
    else $error("seed low byte disturbed high byte");

  data_capture_a: assert property (@(posedge clock) disable iff (!resetn)
    wr_lo && seed_q == st_idle |=> data_q == $past(writedata[7:0]))
    else $error("data byte not captured");

  restart_a: assert property (@(posedge clock) disable iff (!resetn)
    wr_hi && !deep |=> !pend_q)
    else $error("restart left a byte pending");

  crc_quiet_a: assert property (@(posedge clock) disable iff (!resetn)
    !wr_hi && !(wr_lo && seed_q == st_armed) && !pend_q && !deep
    |=> $stable(crc_q))
    else $error("crc changed with no cause");

  // refused writes and stop modes
  frozen_refuse_a: assert property (@(posedge clock) disable iff (!resetn)
    write && !ack_q && frozen && !deep && !pend_q && address == crc_pkg::idx_result_low
    |=> !pend_q && $stable(seed_q))
    else $error("crc write taken while frozen");

  lane_refused_a: assert property (@(posedge clock) disable iff (!resetn)
    write && !ack_q && !byteenable[0] && !pend_q && !deep
    |=> $stable(crc_q) && $stable(seed_q) && $stable(ctl_q))
    else $error("write without lane 0 took effect");

  ctl_write_a: assert property (@(posedge clock) disable iff (!resetn)
    wr_ctl |=> frozen == $past(writedata[crc_pkg::ctl_stop_light])
    && deep == $past(writedata[crc_pkg::ctl_stop_deep]))
    else $error("control write not taken");

  // scenario covers
  seed_cov_c: cover property (@(posedge clock) disable iff (!resetn)
    wr_hi ##[1:8] wr_lo ##[1:8] wr_lo);
  data_cov_c: cover property (@(posedge clock) disable iff (!resetn)
    pend_q && !frozen);
  freeze_cov_c: cover property (@(posedge clock) disable iff (!resetn)
    frozen && write && !ack_q && address == crc_pkg::idx_result_low);
  deep_cov_c: cover property (@(posedge clock) disable iff (!resetn)
    deep ##1 !deep);
endmodule : crc16_ccitt_byte_generator

//--- design/crc_byte_step.sv
`timescale 1ns/1ns
// combinational eight-bit step of the generator
module crc_byte_step (
  // running value and byte in
  input  wire logic [15:0] crc_in,
  input  wire logic [7:0]  data_in,
  // next value
  output logic      [15:0] crc_out
);
  always_comb begin
    logic [15:0] c;
    c = crc_in;
    for (int i = crc_pkg::bits_per_byte - 1; i >= 0; i--) begin
      // v.41 feedback: input bit xored with msb, no augmentation
      if (c[15] ^ data_in[i]) begin
        c = {c[14:0], 1'b0} ^ crc_pkg::crc_poly;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    crc_out = c;
  end
endmodule : crc_byte_step

//--- design/crc_pkg.sv
package crc_pkg;
  // avalon word addresses (byte address = 4 * index)
  localparam logic [3:0]  idx_result_high = 4'h0;
  localparam logic [3:0]  idx_result_low  = 4'h1;
  localparam logic [3:0]  idx_control     = 4'h2;
  localparam logic [3:0]  idx_status      = 4'h3;
  // control bits
  localparam int          ctl_stop_light  = 0;
  localparam int          ctl_stop_deep   = 1;
  // status bits
  localparam int          sts_seed_armed  = 0;
  localparam int          sts_frozen      = 1;
  localparam int          sts_pending     = 2;
  // generator
  localparam logic [15:0] crc_poly        = 16'h1021;
  localparam logic [15:0] crc_reset_value = 16'h0000;
  localparam int          bits_per_byte   = 8;
  localparam logic [31:0] unmapped_value  = 32'h0000_0000;
endpackage : crc_pkg

//--- tb/crc16_ccitt_byte_generator_tb.sv
`timescale 1ns/1ns
module crc16_ccitt_byte_generator_tb;
  logic        clock       = 1'b0;
  logic        resetn      = 1'b0;
  logic [3:0]  address     = 4'h0;
  logic        read        = 1'b0;
  logic        write       = 1'b0;
  logic [31:0] writedata   = 32'h0000_0000;
  logic [3:0]  byteenable  = 4'h1;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [31:0] exp_q[$];
  logic [15:0] m           = 16'h0000;
  int          miscompares = 0;
  int          checks      = 0;
  always #10 clock = ~clock;
  crc16_ccitt_byte_generator dut (.clock(clock), .resetn(resetn), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest));
  ////////////////////////////////////////////////////////////////////////////////
  task close_out;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t readdata %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // bit-serial reference, kept apart from the design's byte step
  function logic [15:0] step(input logic [15:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? crc_pkg::crc_poly : 16'h0000);
    return c;
  endfunction : step
  // one avalon access; an idle edge between accesses avoids double drives
  task bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [31:0] e);
    int n;
    @(posedge clock);
    read      <= ~w;
    write     <= w;
    address   <= a;
    writedata <= {24'h000000, d};
    if (!w) exp_q.push_back(e);
    n = 0;
    // waitrequest is sampled at the rising edge where the answer is taken
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0) begin
      miscompares++;
      close_out();
    end
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task chk_val(input logic [15:0] v);
    bus(1'b0, crc_pkg::idx_result_high, 8'h00, {24'h000000, v[15:8]});
    bus(1'b0, crc_pkg::idx_result_low, 8'h00, {24'h000000, v[7:0]});
  endtask : chk_val
  task seed(input logic [15:0] s);
    bus(1'b1, crc_pkg::idx_result_high, s[15:8], 32'h0);
    bus(1'b1, crc_pkg::idx_result_low, s[7:0], 32'h0);
    m = s;
  endtask : seed
  task data(input logic [7:0] b);
    bus(1'b1, crc_pkg::idx_result_low, b, 32'h0);
    m = step(m, b);
  endtask : data
  task check_str(input logic [15:0] s, input logic [15:0] v);
    seed(s);
    for (int i = 0; i < 9; i++) data(8'h31 + i[7:0]);
    chk_val(v);
  endtask : check_str
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clock)
    if (resetn === 1'b1 && read === 1'b1 && waitrequest === 1'b0)
      cmp(readdata, exp_q.pop_front());
  initial begin
    void'($urandom(32'hd569));
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    chk_val(16'h0000);
    data(8'h41);
    chk_val(16'h58e5);
    check_str(16'h0000, 16'h31c3);
    check_str(16'hffff, 16'h29b1);
    seed(16'($urandom));
    repeat (16) begin
      data(8'($urandom));
      chk_val(m);
    end
    // restart halfway: the high byte lands at once, the low byte waits
    bus(1'b1, crc_pkg::idx_result_high, 8'h5a, 32'h0);
    bus(1'b0, crc_pkg::idx_status, 8'h00, 32'h0000_0001);
    m[15:8] = 8'h5a;
    chk_val(m);
    bus(1'b1, crc_pkg::idx_result_low, 8'ha5, 32'h0);
    m[7:0] = 8'ha5;
    chk_val(m);
    data(8'hc7);
    chk_val(m);
    @(posedge clock) byteenable <= 4'h0;
    bus(1'b1, crc_pkg::idx_result_low, 8'h77, 32'h0);
    @(posedge clock) byteenable <= 4'h1;
    bus(1'b0, 4'h7, 8'h00, crc_pkg::unmapped_value);
    bus(1'b1, 4'h9, 8'hff, 32'h0);
    chk_val(m);
    bus(1'b1, crc_pkg::idx_control, 8'h01, 32'h0);
    bus(1'b0, crc_pkg::idx_control, 8'h00, 32'h0000_0001);
    bus(1'b1, crc_pkg::idx_result_low, 8'h12, 32'h0);
    chk_val(m);
    bus(1'b0, crc_pkg::idx_status, 8'h00, 32'h0000_0002);
    bus(1'b1, crc_pkg::idx_control, 8'h00, 32'h0);
    data(8'h12);
    chk_val(m);
    // arm a seed first: deep stop must drop the arming as well as the value
    bus(1'b1, crc_pkg::idx_result_high, 8'hc3, 32'h0);
    bus(1'b1, crc_pkg::idx_control, 8'h02, 32'h0);
    bus(1'b1, crc_pkg::idx_control, 8'h00, 32'h0);
    bus(1'b0, crc_pkg::idx_status, 8'h00, 32'h0000_0000);
    m = crc_pkg::crc_reset_value;
    chk_val(m);
    data(8'h33);
    chk_val(m);
    repeat (2) @(posedge clock);
    close_out();
  end
endmodule : crc16_ccitt_byte_generator_tb
